// ==== src/racd_pkg.sv ====
package racd_pkg;

  // ==========================================================================
  // register map (byte addresses on the apb side)
  localparam logic [7:0] ADDR_COMMAND_WORD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;

  // ==========================================================================
  // command word layout
  localparam int CMD_START_BIT = 7;
  localparam int CMD_DIR_BIT = 6;
  localparam logic [7:0] COMMAND_WORD_RESET = 8'h00;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // ==========================================================================
  // target select codes
  localparam logic [5:0] SEL_STATUS = 6'h00;
  localparam logic [5:0] SEL_ADC_MODE = 6'h01;
  localparam logic [5:0] SEL_IF_MODE = 6'h02;
  localparam logic [5:0] SEL_CHECKSUM = 6'h03;
  localparam logic [5:0] SEL_RESULT = 6'h04;
  localparam logic [5:0] SEL_GPIO = 6'h06;
  localparam logic [5:0] SEL_ID = 6'h07;
  localparam logic [1:0] SEL_CHANNEL_TOP = 2'h1;
  localparam logic [2:0] SEL_SETUP_TOP = 3'h4;
  localparam logic [2:0] SEL_FILTER_TOP = 3'h5;
  localparam logic [2:0] SEL_OFFSET_TOP = 3'h6;
  localparam logic [2:0] SEL_GAIN_TOP = 3'h7;

  // ==========================================================================
  // status register layout
  localparam int ST_ARMED = 0;
  localparam int ST_DIR = 1;
  localparam int ST_SEL_LSB = 2;
  localparam int ST_CLASS_LSB = 8;
  localparam int ST_INDEX_LSB = 12;
  localparam int ST_VALID = 16;
  localparam int ST_ERR_LSB = 17;
  localparam int ERR_W = 4;
  localparam int ERR_BAD_START = 0;
  localparam int ERR_NO_COMMAND = 1;
  localparam int ERR_UNMAPPED = 2;
  localparam int ERR_DIR_MISMATCH = 3;

  // control register layout
  localparam int CTRL_ENABLE = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    RACD_CLS_NONE = 4'h0,
    RACD_CLS_STATUS = 4'h1,
    RACD_CLS_ADC_MODE = 4'h2,
    RACD_CLS_IF_MODE = 4'h3,
    RACD_CLS_CHECKSUM = 4'h4,
    RACD_CLS_RESULT = 4'h5,
    RACD_CLS_GPIO = 4'h6,
    RACD_CLS_ID = 4'h7,
    RACD_CLS_CHANNEL = 4'h8,
    RACD_CLS_SETUP = 4'h9,
    RACD_CLS_FILTER = 4'hA,
    RACD_CLS_OFFSET = 4'hB,
    RACD_CLS_GAIN = 4'hC
  } racd_class_t;

  typedef enum logic [2:0] {
    RACD_ST_IDLE = 3'b001,
    RACD_ST_WAIT = 3'b010,
    RACD_ST_RESP = 3'b100
  } racd_state_t;

endpackage

// ==== src/racd_target_decode.sv ====
`timescale 1ns/1ps
module racd_target_decode
  import racd_pkg::*;
(
  // target select in
  input wire logic [5:0] target_select,
  // decoded target out
  output racd_class_t target_class,
  output logic [3:0] target_index,
  output logic target_valid
);

  // ==========================================================================
  // decode function
  function automatic racd_class_t decode_class(input logic [5:0] sel);
    racd_class_t cls;
    cls = RACD_CLS_NONE;
    if (sel[5:4] == SEL_CHANNEL_TOP) begin
      cls = RACD_CLS_CHANNEL; // R7
    end else if (sel[5:3] == SEL_SETUP_TOP) begin
      cls = RACD_CLS_SETUP; // R8
    end else if (sel[5:3] == SEL_FILTER_TOP) begin
      cls = RACD_CLS_FILTER; // R9
    end else if (sel[5:3] == SEL_OFFSET_TOP) begin
      cls = RACD_CLS_OFFSET; // R10
    end else if (sel[5:3] == SEL_GAIN_TOP) begin
      cls = RACD_CLS_GAIN; // R10
    end else begin
      // R6
      case (sel)
        SEL_STATUS: cls = RACD_CLS_STATUS;
        SEL_ADC_MODE: cls = RACD_CLS_ADC_MODE;
        SEL_IF_MODE: cls = RACD_CLS_IF_MODE;
        SEL_CHECKSUM: cls = RACD_CLS_CHECKSUM;
        SEL_RESULT: cls = RACD_CLS_RESULT;
        SEL_GPIO: cls = RACD_CLS_GPIO;
        SEL_ID: cls = RACD_CLS_ID;
        default: cls = RACD_CLS_NONE;
      endcase
    end
    return cls;
  endfunction

  // ==========================================================================
  // outputs
  always_comb begin
    target_class = decode_class(target_select);
    target_valid = (target_class != RACD_CLS_NONE);
    // regular pattern: every channel code is distinct, no duplicates
    if (target_class == RACD_CLS_CHANNEL) begin
      target_index = target_select[3:0]; // R7 R11
    end else if (target_class inside {RACD_CLS_SETUP, RACD_CLS_FILTER, RACD_CLS_OFFSET, RACD_CLS_GAIN}) begin
      target_index = {1'b0, target_select[2:0]}; // R8 R9 R10 R11
    end else begin
      target_index = 4'h0;
    end
  end

endmodule // racd_target_decode

// ==== src/racd_sticky.sv ====
`timescale 1ns/1ps
module racd_sticky
  import racd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and clears
  input wire logic [ERR_W-1:0] set_evt,
  input wire logic [ERR_W-1:0] clr_req,
  // flags
  output logic [ERR_W-1:0] flags_ff
);

  logic [ERR_W-1:0] nxt_flags;

  // ==========================================================================
  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    nxt_flags = (flags_ff & ~clr_req) | set_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule // racd_sticky

// ==== src/racd_command_decoder.sv ====
// Operation
// R1 - every register access must be preceded by an accepted command word write
// R2 - the command word fixes target and direction of the next transfer
// R3 - a command is accepted only while its bit 7 is low
// R4 - bit 6 chooses direction: 0 write, 1 read
// R5 - the six low bits select the target of the following data phase
// R6 - codes 0,1,2,3,4,6,7 select status, modes, checksum, result, pins, id
// R7 - codes 010000 to 011111 select channels 0 to 15 by low four bits
// R8 - codes 100000 to 100111 select setups by low three bits
// R9 - codes 101000 to 101111 select filters by low three bits
// R10 - codes 110xxx select offsets, 111xxx select gains, index in low bits
// R11 - duplicated printed codes resolve by the regular pattern
// R12 - command word is write only, resets to zero, disarms after each transfer
`timescale 1ns/1ps
module racd_command_decoder
  import racd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // routed transfer to the addressed register bank
  output logic xfer_req,
  output logic xfer_write,
  output logic [5:0] xfer_select,
  output logic [3:0] xfer_class,
  output logic [3:0] xfer_index,
  output logic [31:0] xfer_wdata,
  input wire logic xfer_done,
  input wire logic [31:0] xfer_rdata
);

  // ==========================================================================
  // state
  racd_state_t state_ff, nxt_state;
  logic [7:0] command_word_ff, nxt_command_word;
  logic armed_ff, nxt_armed;
  logic enable_ff, nxt_enable;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic xfer_req_ff, nxt_xfer_req;
  logic xfer_write_ff, nxt_xfer_write;
  logic [5:0] xfer_select_ff, nxt_xfer_select;
  logic [3:0] xfer_class_ff, nxt_xfer_class;
  logic [3:0] xfer_index_ff, nxt_xfer_index;
  logic [31:0] xfer_wdata_ff, nxt_xfer_wdata;
  logic [ERR_W-1:0] err_set, err_clr, err_flags;

  // decoded view of the stored command
  racd_class_t cmd_class;
  logic [3:0] cmd_index;
  logic cmd_valid;
  logic cmd_dir;
  logic [5:0] cmd_select;

  logic access;
  logic [31:0] status_word;

  assign cmd_dir = command_word_ff[CMD_DIR_BIT]; // R4
  assign cmd_select = command_word_ff[5:0]; // R5
  assign access = psel && penable;

  // ==========================================================================
  // submodules
  racd_target_decode u_decode (
    .target_select(cmd_select),
    .target_class(cmd_class),
    .target_index(cmd_index),
    .target_valid(cmd_valid)
  );

  racd_sticky u_errors (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(err_set),
    .clr_req(err_clr),
    .flags_ff(err_flags)
  );

  // ==========================================================================
  // status view
  always_comb begin
    status_word = '0;
    status_word[ST_ARMED] = armed_ff;
    status_word[ST_DIR] = cmd_dir;
    status_word[ST_SEL_LSB +: 6] = cmd_select;
    status_word[ST_CLASS_LSB +: 4] = cmd_class;
    status_word[ST_INDEX_LSB +: 4] = cmd_index;
    status_word[ST_VALID] = cmd_valid;
    status_word[ST_ERR_LSB +: ERR_W] = err_flags;
  end

  // ==========================================================================
  // apb and transfer sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_command_word = command_word_ff;
    nxt_armed = armed_ff;
    nxt_enable = enable_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_xfer_req = xfer_req_ff;
    nxt_xfer_write = xfer_write_ff;
    nxt_xfer_select = xfer_select_ff;
    nxt_xfer_class = xfer_class_ff;
    nxt_xfer_index = xfer_index_ff;
    nxt_xfer_wdata = xfer_wdata_ff;
    err_set = '0;
    err_clr = '0;
    case (state_ff)
      RACD_ST_IDLE: begin
        if (access) begin
          nxt_state = RACD_ST_RESP;
          nxt_pready = 1'b1;
          nxt_prdata = '0;
          case (paddr)
            ADDR_COMMAND_WORD: begin
              // write only: reads return zero
              if (pwrite && enable_ff) begin
                if (pwdata[CMD_START_BIT] == 1'b0) begin
                  nxt_command_word = pwdata[7:0]; // R2 R3
                  nxt_armed = 1'b1; // R1
                end else begin
                  // qualifier high: byte is not a command, prior state kept
                  err_set[ERR_BAD_START] = 1'b1; // R3
                  nxt_pslverr = 1'b1;
                end
              end
            end
            ADDR_DATA: begin
              if (!enable_ff || !armed_ff) begin
                err_set[ERR_NO_COMMAND] = 1'b1; // R1
                nxt_pslverr = 1'b1;
              end else if (!cmd_valid) begin
                err_set[ERR_UNMAPPED] = 1'b1;
                nxt_pslverr = 1'b1;
                nxt_armed = 1'b0; // R12
              end else if (pwrite != (cmd_dir == DIR_WRITE)) begin
                // apb direction disagrees with the command direction
                err_set[ERR_DIR_MISMATCH] = 1'b1; // R4
                nxt_pslverr = 1'b1;
                nxt_armed = 1'b0; // R12
              end else begin
                // hold the apb access until the addressed bank answers
                nxt_state = RACD_ST_WAIT;
                nxt_pready = 1'b0;
                nxt_xfer_req = 1'b1; // R2
                nxt_xfer_write = (cmd_dir == DIR_WRITE); // R4
                nxt_xfer_select = cmd_select; // R5
                nxt_xfer_class = cmd_class; // R6 R7 R8 R9 R10
                nxt_xfer_index = cmd_index; // R7 R8 R9 R10
                nxt_xfer_wdata = pwrite ? pwdata : '0;
              end
            end
            ADDR_STATUS: begin
              if (pwrite) begin
                err_clr = pwdata[ST_ERR_LSB +: ERR_W];
              end else begin
                nxt_prdata = status_word;
              end
            end
            ADDR_CONTROL: begin
              if (pwrite) begin
                nxt_enable = pwdata[CTRL_ENABLE];
                // disabling drops any pending command
                if (!pwdata[CTRL_ENABLE]) begin
                  nxt_armed = 1'b0;
                end
              end else begin
                nxt_prdata[CTRL_ENABLE] = enable_ff;
              end
            end
            default: begin
              nxt_pslverr = 1'b1;
            end
          endcase
        end
      end
      RACD_ST_WAIT: begin
        if (xfer_done) begin
          nxt_state = RACD_ST_RESP;
          nxt_pready = 1'b1;
          nxt_xfer_req = 1'b0;
          nxt_prdata = xfer_write_ff ? '0 : xfer_rdata;
          nxt_armed = 1'b0; // R12
        end
      end
      RACD_ST_RESP: begin
        // pready is high this cycle; the master ends the access now
        nxt_state = RACD_ST_IDLE;
      end
      default: begin
        nxt_state = RACD_ST_IDLE;
        nxt_xfer_req = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RACD_ST_IDLE;
      command_word_ff <= COMMAND_WORD_RESET; // R12
      armed_ff <= 1'b0; // R1
      enable_ff <= CTRL_ENABLE_RESET;
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      xfer_req_ff <= 1'b0;
      xfer_write_ff <= 1'b0;
      xfer_select_ff <= '0;
      xfer_class_ff <= '0;
      xfer_index_ff <= '0;
      xfer_wdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      command_word_ff <= nxt_command_word;
      armed_ff <= nxt_armed;
      enable_ff <= nxt_enable;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      xfer_req_ff <= nxt_xfer_req;
      xfer_write_ff <= nxt_xfer_write;
      xfer_select_ff <= nxt_xfer_select;
      xfer_class_ff <= nxt_xfer_class;
      xfer_index_ff <= nxt_xfer_index;
      xfer_wdata_ff <= nxt_xfer_wdata;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign xfer_req = xfer_req_ff;
  assign xfer_write = xfer_write_ff;
  assign xfer_select = xfer_select_ff;
  assign xfer_class = xfer_class_ff;
  assign xfer_index = xfer_index_ff;
  assign xfer_wdata = xfer_wdata_ff;

endmodule // racd_command_decoder

// ==== verification/racd_assertions.sv ====
`timescale 1ns/1ps
module racd_checker
  import racd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // routed transfer
  input wire logic xfer_req,
  input wire logic xfer_write,
  input wire logic [5:0] xfer_select,
  input wire logic [3:0] xfer_class,
  input wire logic [3:0] xfer_index,
  input wire logic xfer_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // assertions
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_req_held: assert property (xfer_req ##1 xfer_req |-> $stable(xfer_write) && $stable(xfer_select))
    else $error("transfer changed while pending");
  a_done_answer: assert property (xfer_req && xfer_done |=> pready && !xfer_req) else $error("no answer");
  a_cmd_no_xfer: assert property (psel && penable && paddr == ADDR_COMMAND_WORD && !xfer_req |=> !xfer_req)
    else $error("command started transfer");
  a_chan_map: assert property (xfer_req && xfer_select[5:4] == SEL_CHANNEL_TOP |->
    xfer_class == RACD_CLS_CHANNEL && xfer_index == xfer_select[3:0]) else $error("channel decode");
  a_setup_map: assert property (xfer_req && xfer_select[5:3] == SEL_SETUP_TOP |->
    xfer_class == RACD_CLS_SETUP && xfer_index == {1'b0, xfer_select[2:0]}) else $error("setup decode");
  a_filter_map: assert property (xfer_req && xfer_select[5:3] == SEL_FILTER_TOP |->
    xfer_class == RACD_CLS_FILTER && xfer_index == {1'b0, xfer_select[2:0]}) else $error("filter decode");
  a_cal_map: assert property (xfer_req && xfer_select[5:4] == 2'h3 |->
    xfer_class == (xfer_select[3] ? RACD_CLS_GAIN : RACD_CLS_OFFSET)) else $error("calibration decode");
  a_id_map: assert property (xfer_req && xfer_select == SEL_ID |-> xfer_class == RACD_CLS_ID)
    else $error("id decode");
  c_read: cover property (xfer_req && xfer_done && !xfer_write);
  c_write: cover property (xfer_req && xfer_done && xfer_write);
  c_refused: cover property (pslverr);
endmodule // racd_checker

bind racd_command_decoder racd_checker i_racd_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .xfer_req(xfer_req),
  .xfer_write(xfer_write), .xfer_select(xfer_select), .xfer_class(xfer_class), .xfer_index(xfer_index),
  .xfer_done(xfer_done));

// ==== verification/racd_bank_model.sv ====
`timescale 1ns/1ps
module racd_bank_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // routed transfer
  input wire logic xfer_req,
  input wire logic xfer_write,
  input wire logic [5:0] xfer_select,
  input wire logic [31:0] xfer_wdata,
  input wire logic [3:0] lat,
  output logic xfer_done,
  output logic [31:0] xfer_rdata
);
  logic [31:0] mem [64];
  logic [3:0] cnt;
  // ==========================================================================
  // bank: answers lat+1 cycles after the request; data line toggles except while counting and on a read answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      xfer_done <= 1'b0;
      xfer_rdata <= 32'h0;
    end else if (xfer_req && !xfer_done) begin
      if (cnt == lat) begin
        cnt <= 4'h0;
        xfer_done <= 1'b1;
        if (xfer_write) mem[xfer_select] <= xfer_wdata;
        xfer_rdata <= xfer_write ? ~xfer_rdata : mem[xfer_select];
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      xfer_done <= 1'b0;
      xfer_rdata <= ~xfer_rdata;
    end
  end
endmodule // racd_bank_model

// ==== verification/tb_racd_command_decoder.sv ====
`timescale 1ns/1ps
module tb_racd_command_decoder import racd_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, bad;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, xfer_wdata, xfer_rdata;
  logic xfer_req, xfer_write, xfer_done, cap_wr;
  logic [5:0] xfer_select, cap_sel, s;
  logic [3:0] xfer_class, xfer_index, lat;
  logic [7:0] cap_ci;
  int n_mismatch = 0, n_checks = 0, cyc = 0;

  racd_command_decoder i_racd_command_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_select(xfer_select), .xfer_class(xfer_class),
    .xfer_index(xfer_index), .xfer_wdata(xfer_wdata), .xfer_done(xfer_done), .xfer_rdata(xfer_rdata));
  racd_bank_model i_racd_bank_model (.pclk(pclk), .presetn(presetn), .xfer_req(xfer_req),
    .xfer_write(xfer_write), .xfer_select(xfer_select), .xfer_wdata(xfer_wdata), .lat(lat),
    .xfer_done(xfer_done), .xfer_rdata(xfer_rdata));

  // ==========================================================================
  // clock, timeout, capture of routed transfer
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      conclude();
    end
    if (xfer_req === 1'b1) begin
      cap_sel <= xfer_select;
      cap_wr <= xfer_write;
      cap_ci <= {xfer_class, xfer_index};
    end
  end

  // ==========================================================================
  // tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n == 40) begin
      n_mismatch++;
      $display("wrong value at %0t: no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // {class, index} expected for a mapped select code
  function automatic logic [7:0] exp_ci(input logic [5:0] c);
    if (c[5:4] == 2'h1) return {4'h8, c[3:0]};
    if (c[5]) return {4'h9 + {2'h0, c[4:3]}, 1'b0, c[2:0]};
    return {(c[2:0] < 3'h5) ? {1'b0, c[2:0]} + 4'h1 : {1'b0, c[2:0]}, 4'h0};
  endfunction

  // ==========================================================================
  // tests
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset command word selects the status target, so the decoded view is valid
    apb(1'b0, ADDR_STATUS, 32'h0); chk({er, rd}, {1'b0, 15'h0, 1'b1, 4'h0, 4'h1, 8'h00}, "status reset");
    apb(1'b0, ADDR_COMMAND_WORD, 32'h0); chk({er, rd}, 33'h0, "command read");
    apb(1'b0, 8'h10, 32'h0); chk({er, rd}, {1'b1, 32'h0}, "unmapped");
    apb(1'b0, ADDR_DATA, 32'h0); chk(33'(er), 33'h1, "no command");
    $display("reset test done");
    apb(1'b1, ADDR_COMMAND_WORD, 32'h01);
    apb(1'b1, ADDR_COMMAND_WORD, 32'hC2); chk(33'(er), 33'h1, "start bit");
    apb(1'b1, ADDR_DATA, 32'h1234); chk({er, 26'h0, cap_sel}, 33'h1, "prior kept");
    $display("start bit test done");
    for (int i = 0; i < 64; i++) begin
      s = i[5:0];
      d = {26'h0, s} ^ 32'h5A5A0000;
      bad = (s == 6'h05) || (s[5:3] == 3'h1);
      lat <= {2'h0, s[1:0]};
      apb(1'b1, ADDR_COMMAND_WORD, {24'h0, 1'b0, DIR_WRITE, s});
      apb(1'b1, ADDR_DATA, d); chk(33'(er), 33'(bad), "refusal");
      if (!bad) begin
        chk(33'({cap_sel, cap_wr, cap_ci}), 33'({s, 1'b1, exp_ci(s)}), "routing");
        apb(1'b1, ADDR_COMMAND_WORD, {24'h0, 1'b0, DIR_READ, s});
        apb(1'b0, ADDR_DATA, 32'h0); chk({er, rd}, {1'b0, d}, "read back");
      end
    end
    $display("decode test done");
    apb(1'b1, ADDR_COMMAND_WORD, 32'h41);
    apb(1'b1, ADDR_DATA, 32'h7); chk(33'(er), 33'h1, "direction");
    apb(1'b0, ADDR_DATA, 32'h0); chk(33'(er), 33'h1, "disarmed");
    apb(1'b1, ADDR_COMMAND_WORD, 32'h02);
    apb(1'b1, ADDR_COMMAND_WORD, 32'h03);
    apb(1'b1, ADDR_DATA, 32'h9); chk({er, 26'h0, cap_sel}, 33'h3, "replaced");
    apb(1'b1, ADDR_DATA, 32'h9); chk(33'(er), 33'h1, "one access");
    $display("order test done");
    apb(1'b1, ADDR_CONTROL, 32'h0);
    apb(1'b0, ADDR_CONTROL, 32'h0); chk({er, rd}, 33'h0, "disabled");
    apb(1'b1, ADDR_COMMAND_WORD, 32'h05); chk(33'(er), 33'h0, "ignored");
    apb(1'b1, ADDR_CONTROL, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({er, rd}, {1'b0, 11'h0, 4'hF, 1'b1, 4'h0, 4'h4, 6'h03, 2'h0}, "status flags");
    apb(1'b1, ADDR_STATUS, 32'h001E0000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({er, rd}, {1'b0, 15'h0, 1'b1, 4'h0, 4'h4, 6'h03, 2'h0}, "status clear");
    $display("control test done");
    conclude();
  end
endmodule // tb_racd_command_decoder
